// ==== rtl/rfp_regs.vh ====
// timing constants of the rail fault protection block
// assumes a 100 MHz core clock
`ifndef RFP_REGS_VH
`define RFP_REGS_VH

`define RFP_CLK_PERIOD_NS 10
`define RFP_OV_DEGLITCH_NS 1000
`define RFP_UV_DEGLITCH_NS 3000
`define RFP_LOCKOUT_DEGLITCH_NS 3000
`define RFP_TRIGGER_DELAY_NS 10000
`define RFP_ACTION_DELAY_NS 5000
`define RFP_SETTLE_NS 2000

// cycle counts at the 10 ns clock, sized for the 16-bit counters
`define RFP_OV_DEGLITCH_CYC 16'h0064
`define RFP_UV_DEGLITCH_CYC 16'h012c
`define RFP_LOCKOUT_CYC 16'h012c
`define RFP_TRIGGER_CYC 16'h03e8
`define RFP_ACTION_CYC 16'h01f4
`define RFP_SETTLE_CYC 16'h00c8
`define RFP_NO_QUAL_CYC 16'h0001

`endif

// ==== rtl/rfp_deglitch.v ====
// three-stage synchroniser with persistence qualification
// assumes i_pin is asynchronous to i_core_clk
module rfp_deglitch #(
    parameter [15:0] CYCLES = 16'h0001
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_pin,
    output reg o_level
);

// =====================================================
// synchroniser
reg sync_a;
reg sync_b;
reg sync_c;
reg [15:0] cnt;
wire agree_high;
wire agree_low;

assign agree_high = sync_b & sync_c;
assign agree_low = ~sync_b & ~sync_c;

always @(posedge i_core_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        sync_a <= 1'b0;
        sync_b <= 1'b0;
        sync_c <= 1'b0;
    end
    else
    begin
        sync_a <= i_pin;
        sync_b <= sync_a;
        sync_c <= sync_b;
    end
end

// =====================================================
// persistence counter
always @(posedge i_core_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        cnt <= 16'h0000;
        o_level <= 1'b0;
    end
    else if (agree_high)
    begin
        if (cnt >= CYCLES - 16'h0001)
            o_level <= 1'b1;
        else
            cnt <= cnt + 16'h0001;
    end
    else if (agree_low)
    begin
        cnt <= 16'h0000;
        o_level <= 1'b0;
    end
end

endmodule

// ==== rtl/rfp_rail_fault_protection.v ====
// fault protection for the second output rail
// assumes comparator results arrive as asynchronous pin levels
`include "rfp_regs.vh"

module rfp_rail_fault_protection #(
    parameter PHASES = 2
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_por_done,
    input wire i_ctrl_enable,
    input wire i_avg_over_sustained_current_limit,
    input wire i_cycle_over_peak_current_limit,
    input wire i_filtered_over_limit,
    input wire i_target_voltage_code_below_0v9,
    input wire i_sense_over_fixed_ov,
    input wire i_sense_over_ref_ov,
    input wire i_sense_below_zero,
    input wire i_sense_under_ref_uv,
    input wire i_analog_supply_low,
    input wire i_digital_supply_pin_low,
    input wire [PHASES-1:0] i_phase_active,
    input wire [PHASES-1:0] i_pwm_high,
    input wire [PHASES-1:0] i_pwm_low,
    output reg o_overcurrent_alert_n,
    output reg o_sustained_current_trip,
    output reg o_peak_current_trip,
    output reg o_overcurrent_shutdown,
    output reg o_overvoltage_latch,
    output reg o_negative_voltage_guard,
    output reg o_undervoltage_latch,
    output reg o_supply_lockout,
    output reg o_soft_shutdown_req,
    output reg [PHASES-1:0] o_high_side_on,
    output reg [PHASES-1:0] o_low_side_on
);

// =====================================================
// oc sequencer states
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_ACTION = 2'b01;
localparam [1:0] ST_SETTLE = 2'b10;
localparam [1:0] ST_OFF = 2'b11;

localparam [15:0] TRIG_CYC = `RFP_TRIGGER_CYC;
localparam [15:0] OV_CYC = `RFP_OV_DEGLITCH_CYC;
localparam [15:0] UV_CYC = `RFP_UV_DEGLITCH_CYC;
localparam [15:0] LOCK_CYC = `RFP_LOCKOUT_CYC;
localparam [15:0] ONE_CYC = `RFP_NO_QUAL_CYC;
localparam [15:0] ACT_CYC = `RFP_ACTION_CYC;
localparam [15:0] SETTLE_CYC = `RFP_SETTLE_CYC;

// =====================================================
// qualified inputs
wire avg_high;
wire peak_high;
wire filt_high;
wire below_0v9;
wire ov_fixed;
wire ov_ref;
wire neg_sense;
wire uv_sense;
wire vcc_low;
wire dig_low;
wire por_done;
wire enable;

rfp_deglitch #(.CYCLES(TRIG_CYC)) u_avg
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_avg_over_sustained_current_limit),
    .o_level(avg_high)
);

rfp_deglitch #(.CYCLES(ONE_CYC)) u_peak
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_cycle_over_peak_current_limit),
    .o_level(peak_high)
);

rfp_deglitch #(.CYCLES(ONE_CYC)) u_filt
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_filtered_over_limit),
    .o_level(filt_high)
);

rfp_deglitch #(.CYCLES(ONE_CYC)) u_vid
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_target_voltage_code_below_0v9),
    .o_level(below_0v9)
);

rfp_deglitch #(.CYCLES(OV_CYC)) u_ovf
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sense_over_fixed_ov),
    .o_level(ov_fixed)
);

rfp_deglitch #(.CYCLES(OV_CYC)) u_ovr
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sense_over_ref_ov),
    .o_level(ov_ref)
);

rfp_deglitch #(.CYCLES(ONE_CYC)) u_neg
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sense_below_zero),
    .o_level(neg_sense)
);

rfp_deglitch #(.CYCLES(UV_CYC)) u_uv
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sense_under_ref_uv),
    .o_level(uv_sense)
);

rfp_deglitch #(.CYCLES(LOCK_CYC)) u_vcc
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_analog_supply_low),
    .o_level(vcc_low)
);

rfp_deglitch #(.CYCLES(LOCK_CYC)) u_dig
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_digital_supply_pin_low),
    .o_level(dig_low)
);

rfp_deglitch #(.CYCLES(ONE_CYC)) u_por
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_por_done),
    .o_level(por_done)
);

rfp_deglitch #(.CYCLES(ONE_CYC)) u_en
(
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_ctrl_enable),
    .o_level(enable)
);

// =====================================================
// over-current sequencer
reg [1:0] state;
reg [1:0] next_state;
reg [15:0] timer;
reg [15:0] next_timer;
wire any_trip;
wire armed;

assign any_trip = avg_high | peak_high;
assign armed = por_done & enable;

always @*
begin
    next_state = state;
    next_timer = timer;
    case (state)
        ST_IDLE:
        begin
            next_timer = 16'h0000;
            if (armed && any_trip)
                next_state = ST_ACTION;
        end
        ST_ACTION:
        begin
            if (timer >= ACT_CYC - 16'h0001)
            begin
                next_state = ST_SETTLE;
                next_timer = 16'h0000;
            end
            else
                next_timer = timer + 16'h0001;
        end
        ST_SETTLE:
        begin
            if (timer >= SETTLE_CYC - 16'h0001)
            begin
                next_timer = 16'h0000;
                if (filt_high)
                    next_state = ST_OFF;
                else
                    next_state = ST_IDLE;
            end
            else
                next_timer = timer + 16'h0001;
        end
        ST_OFF:
        begin
            next_timer = 16'h0000;
        end
        default:
        begin
            next_state = ST_IDLE;
            next_timer = 16'h0000;
        end
    endcase
    if (!armed)
    begin
        next_state = ST_IDLE;
        next_timer = 16'h0000;
    end
end

always @(posedge i_core_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        state <= ST_IDLE;
        timer <= 16'h0000;
    end
    else
    begin
        state <= next_state;
        timer <= next_timer;
    end
end

// =====================================================
// trip flags and alert
always @(posedge i_core_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_sustained_current_trip <= 1'b0;
        o_peak_current_trip <= 1'b0;
        o_overcurrent_alert_n <= 1'b1;
        o_overcurrent_shutdown <= 1'b0;
    end
    else
    begin
        o_sustained_current_trip <= armed & avg_high;
        o_peak_current_trip <= armed & peak_high;
        o_overcurrent_alert_n <= ~(armed &
            (any_trip | (state != ST_IDLE)));
        o_overcurrent_shutdown <= (next_state == ST_OFF);
    end
end

// =====================================================
// voltage latches
wire ov_cond;

assign ov_cond = below_0v9 ? ov_fixed : ov_ref;

always @(posedge i_core_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_overvoltage_latch <= 1'b0;
        o_undervoltage_latch <= 1'b0;
        o_negative_voltage_guard <= 1'b0;
        o_supply_lockout <= 1'b0;
        o_soft_shutdown_req <= 1'b0;
    end
    else
    begin
        if (!armed)
        begin
            o_overvoltage_latch <= 1'b0;
            o_undervoltage_latch <= 1'b0;
        end
        else
        begin
            if (ov_cond)
                o_overvoltage_latch <= 1'b1;
            if (uv_sense)
                o_undervoltage_latch <= 1'b1;
        end
        o_negative_voltage_guard <= armed & o_overvoltage_latch &
            neg_sense;
        o_supply_lockout <= vcc_low | dig_low;
        o_soft_shutdown_req <= armed &
            ((o_overvoltage_latch | ov_cond) |
            (o_undervoltage_latch | uv_sense));
    end
end

// =====================================================
// gate drive
always @(posedge i_core_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_high_side_on <= {PHASES{1'b0}};
        o_low_side_on <= {PHASES{1'b0}};
    end
    else if (o_supply_lockout || vcc_low || dig_low)
    begin
        o_high_side_on <= {PHASES{1'b0}};
        o_low_side_on <= {PHASES{1'b0}};
    end
    else if (o_undervoltage_latch)
    begin
        o_high_side_on <= {PHASES{1'b0}};
        o_low_side_on <= {PHASES{1'b0}};
    end
    else if (o_overvoltage_latch)
    begin
        o_high_side_on <= {PHASES{1'b0}};
        if (neg_sense)
            o_low_side_on <= {PHASES{1'b0}};
        else
            o_low_side_on <= i_phase_active;
    end
    else if (state == ST_OFF || !armed)
    begin
        o_high_side_on <= {PHASES{1'b0}};
        o_low_side_on <= {PHASES{1'b0}};
    end
    else
    begin
        o_high_side_on <= i_pwm_high & i_phase_active;
        o_low_side_on <= i_pwm_low & i_phase_active;
    end
end

endmodule

// ==== verification/rfp_assertions.sv ====
// port assertions for the rail fault protection block
// assumes one core clock and an active-high async reset
module rfp_assertions #(
    parameter PHASES = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_por_done,
    input wire logic i_ctrl_enable,
    input wire logic i_avg_over_sustained_current_limit,
    input wire logic i_target_voltage_code_below_0v9,
    input wire logic i_sense_over_fixed_ov,
    input wire logic i_sense_over_ref_ov,
    input wire logic i_sense_under_ref_uv,
    input wire logic i_analog_supply_low,
    input wire logic i_digital_supply_pin_low,
    input wire logic [PHASES-1:0] i_phase_active,
    input wire logic o_overcurrent_alert_n,
    input wire logic o_sustained_current_trip,
    input wire logic o_peak_current_trip,
    input wire logic o_overcurrent_shutdown,
    input wire logic o_overvoltage_latch,
    input wire logic o_negative_voltage_guard,
    input wire logic o_undervoltage_latch,
    input wire logic o_supply_lockout,
    input wire logic o_soft_shutdown_req,
    input wire logic [PHASES-1:0] o_high_side_on,
    input wire logic [PHASES-1:0] o_low_side_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // run-length counters of the causes
    logic [5:0] src;
    logic [10:0] n [6];
    assign src = {i_target_voltage_code_below_0v9 ? i_sense_over_fixed_ov
        : i_sense_over_ref_ov, i_sense_under_ref_uv,
        i_analog_supply_low | i_digital_supply_pin_low,
        i_avg_over_sustained_current_limit, !o_overcurrent_alert_n,
        i_por_done & i_ctrl_enable};
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        for (int k = 0; k < 6; k++)
        begin
            if (i_rst)
                n[k] <= 11'h0;
            else
                n[k] <= src[k] ? n[k] + {10'h0, ~&n[k]} : 11'h0;
        end
    end
    // ========================================
    // assertions
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_ov_gates: assert property ((o_overvoltage_latch &&
        !o_negative_voltage_guard && !o_undervoltage_latch &&
        !o_supply_lockout)[*2] |-> o_high_side_on == '0 &&
        o_low_side_on == $past(i_phase_active))
        else $error("gates wrong under over-voltage");
    a_nv_off: assert property (o_negative_voltage_guard[*2] |->
        o_high_side_on == '0 && o_low_side_on == '0)
        else $error("switches on under negative guard");
    a_uv_off: assert property (o_undervoltage_latch[*2] |->
        o_high_side_on == '0 && o_low_side_on == '0)
        else $error("switches on under under-voltage");
    a_lock_off: assert property (o_supply_lockout[*2] |->
        o_high_side_on == '0 && o_low_side_on == '0)
        else $error("switches on under lockout");
    a_soft_req: assert property (o_soft_shutdown_req ==
        (o_overvoltage_latch || o_undervoltage_latch))
        else $error("soft shutdown request wrong");
    a_nv_needs_ov: assert property (o_negative_voltage_guard |->
        o_overvoltage_latch || $past(o_overvoltage_latch))
        else $error("negative guard without latch");
    a_ov_qual: assert property ($rose(o_overvoltage_latch) |->
        n[5] >= 11'd100 && n[0] >= 11'd3)
        else $error("over-voltage latched too early");
    a_uv_qual: assert property ($rose(o_undervoltage_latch) |->
        n[4] >= 11'd300) else $error("under-voltage latched too early");
    a_lock_qual: assert property ($rose(o_supply_lockout) |->
        n[3] >= 11'd300) else $error("lockout too early");
    a_sust_qual: assert property ($rose(o_sustained_current_trip) |->
        n[2] >= 11'd1000) else $error("sustained trip too early");
    a_alert_trip: assert property ((o_peak_current_trip ||
        o_sustained_current_trip)[*2] |-> !o_overcurrent_alert_n)
        else $error("alert missing on trip");
    a_oc_delay: assert property ($rose(o_overcurrent_shutdown) |->
        n[1] >= 11'd695) else $error("shutdown before delays");
    a_latch_hold: assert property ($fell(o_overvoltage_latch) ||
        $fell(o_undervoltage_latch) |-> n[0] < 11'd8)
        else $error("latch released while armed");
    cover property ($rose(o_negative_voltage_guard));
    cover property ($rose(o_overcurrent_shutdown));
    cover property ($rose(o_supply_lockout));
endmodule

bind rfp_rail_fault_protection rfp_assertions #(.PHASES(PHASES)) u_chk (.*);

// ==== verification/rfp_rail_model.sv ====
// rail sense comparators seen by the protection block
// assumes level codes from the bench, changed on falling edges
module rfp_rail_model (
    input wire logic [2:0] i_level,
    output logic o_over_ref,
    output logic o_over_fixed,
    output logic o_below_zero,
    output logic o_under_ref
);
    timeunit 1ns;
    timeprecision 1ps;
    // 1 over reference only, 2 over both, 3 low, 4 negative
    assign o_over_ref = i_level == 3'h1 || i_level == 3'h2;
    assign o_over_fixed = i_level == 3'h2;
    assign o_under_ref = i_level == 3'h3 || i_level == 3'h4;
    assign o_below_zero = i_level == 3'h4;
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the rail fault protection block
// assumes the comparator model and the bound checker
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // stimulus and scoreboard
    logic clk = 0, rst = 1, por = 0, en = 0, avg = 0, pk = 0, filt = 0;
    logic low_t = 0, alo = 0, dlo = 0, smp = 0;
    logic ovr, ovf, neg, uvr;
    logic [2:0] lvl = 3'h1;
    logic [1:0] ph = 2'h3, pw = 2'h1;
    logic [15:0] r = 16'hb197;
    logic [12:0] q[$];
    wire [8:0] st;
    wire [1:0] hs, ls;
    int mismatches = 0, cmp_count = 0;
    always #5 clk = ~clk;
    rfp_rail_model pm (.i_level(lvl), .o_over_ref(ovr),
        .o_over_fixed(ovf), .o_below_zero(neg), .o_under_ref(uvr));
    rfp_rail_fault_protection #(.PHASES(2)) dut (
        .i_core_clk(clk), .i_rst(rst), .i_por_done(por),
        .i_ctrl_enable(en), .i_avg_over_sustained_current_limit(avg),
        .i_cycle_over_peak_current_limit(pk),
        .i_filtered_over_limit(filt),
        .i_target_voltage_code_below_0v9(low_t),
        .i_sense_over_fixed_ov(ovf), .i_sense_over_ref_ov(ovr),
        .i_sense_below_zero(neg), .i_sense_under_ref_uv(uvr),
        .i_analog_supply_low(alo), .i_digital_supply_pin_low(dlo),
        .i_phase_active(ph), .i_pwm_high(pw), .i_pwm_low(~pw),
        .o_overcurrent_alert_n(st[8]), .o_sustained_current_trip(st[7]),
        .o_peak_current_trip(st[6]), .o_overcurrent_shutdown(st[5]),
        .o_overvoltage_latch(st[4]), .o_negative_voltage_guard(st[3]),
        .o_undervoltage_latch(st[2]), .o_supply_lockout(st[1]),
        .o_soft_shutdown_req(st[0]), .o_high_side_on(hs),
        .o_low_side_on(ls));
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH status exp %h seen %h", exp, seen);
        end
    endtask
    // note the expectation, then let the watcher compare
    task automatic step(input int c, input logic [8:0] s,
        input logic [1:0] h, input logic [1:0] l);
        repeat (c) @(negedge clk);
        q.push_back({s, h, l});
        smp = 1;
        @(negedge clk);
        smp = 0;
    endtask
    always @(posedge smp)
    begin
        if (q.size() > 0)
            chk({st, hs, ls}, q.pop_front());
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic roll;
        r = lfsr(r);
        pw = r[1:0];
    endtask
    task automatic disarm;
        en = 0;
        step(10, 9'h100, 2'h0, 2'h0);
        en = 1;
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        print_verdict;
    end
    // ========================================
    // scenarios
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 0;
        step(150, 9'h100, 2'h0, 2'h0);
        lvl = 3'h0;
        por = 1;
        en = 1;
        step(20, 9'h100, pw, ~pw);
        lvl = 3'h1;
        step(50, 9'h100, pw, ~pw);
        roll();
        ph = r[3:2] | 2'h1;
        step(100, 9'h111, 2'h0, ph);
        lvl = 3'h4;
        step(10, 9'h119, 2'h0, 2'h0);
        lvl = 3'h0;
        step(10, 9'h111, 2'h0, ph);
        ph = 2'h3;
        disarm();
        lvl = 3'h4;
        step(20, 9'h100, pw, ~pw);
        $display("over-voltage test done");
        low_t = 1;
        lvl = 3'h1;
        step(200, 9'h100, pw, ~pw);
        lvl = 3'h2;
        step(150, 9'h111, 2'h0, 2'h3);
        low_t = 0;
        lvl = 3'h3;
        disarm();
        step(250, 9'h100, pw, ~pw);
        step(150, 9'h105, 2'h0, 2'h0);
        lvl = 3'h0;
        step(20, 9'h105, 2'h0, 2'h0);
        disarm();
        $display("threshold and under-voltage test done");
        for (int k = 0; k < 2; k++)
        begin
            roll();
            {dlo, alo} = 2'h1 << k;
            step(250, 9'h100, pw, ~pw);
            step(150, 9'h102, 2'h0, 2'h0);
            {dlo, alo} = 2'h0;
            step(20, 9'h100, pw, ~pw);
        end
        $display("lockout test done");
        pk = 1;
        step(10, 9'h040, pw, ~pw);
        pk = 0;
        step(100, 9'h000, pw, ~pw);
        step(700, 9'h100, pw, ~pw);
        filt = 1;
        pk = 1;
        step(10, 9'h040, pw, ~pw);
        pk = 0;
        step(750, 9'h020, 2'h0, 2'h0);
        filt = 0;
        disarm();
        avg = 1;
        step(500, 9'h100, pw, ~pw);
        step(600, 9'h080, pw, ~pw);
        avg = 0;
        $display("over-current test done");
        print_verdict();
    end
endmodule
